// ===== rtl/sigma_delta_adc_control_regs.sv
// Control registers and word timing for a delta-sigma converter front end
//
// Overview of operation
// - Reference gain bits 6:5 give 1, 1/2, 1/4; code 11 reserved.
// - Converter gain bits 4:3 give 1, 2, 4 or 8.
// - Amplifier gain bits 2:0 give two to the power of the code.
// - Input config bit 7 picks common level 1.05 V or 1.25 V; resets 1.
// - Input config bit 6 shorts the selected amplifier inputs when set.
// - Offset trim bits 3:1: zero at 000/100, plus or minus quarters.
// - Negative select bits 5:3: ch1, ch3, supply/5, common, sensor minus.
// - Positive select bits 2:0: ch0,2,4,5,6,7, common, sensor plus.
// - Result bytes high, middle, low hold bits 23:16, 15:8, 7:0.
// - Soft reset bit pulsed high then low resets filter, restarts.
// - Control 0 bit 6 selects sleep; clearing returns normal mode.
// - Power-off bit resets to 1 and overrides sleep and soft reset.
// - Rate bits 4:2 give 16384 shifted right; chop 2 normal, 1 low.
// - Control 0 bit 0 selects internal or external reference.
// - Control 1 bits 7 and 6 select mode and clock divide 30 or 12.
// - Control 1 bits 4 and 3 enable negative and positive buffers.
// - Latch bit holds results; no flag, no interrupt while set.
// - Unimplemented register bits read as zero, except control 1 bit 5.
// - Conversion end sets flag bit 1 and pulses interrupt; software clears.
// - Word rate is converter clock over chop times oversampling ratio.
// - With latch off every new result overwrites the result bytes.
//
// The register addresses and the strobed register port were chosen for this implementation.
`default_nettype none
module sigma_delta_adc_control_regs (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [7:0]  rdData,
  input  wire logic [23:0] resultIn,
  output logic      [2:0]  refGainDiv,
  output logic      [3:0]  convGain,
  output logic      [7:0]  ampGain,
  output logic             commonLevelHigh,
  output logic             inputShort,
  output logic             offsetNeg,
  output logic      [1:0]  offsetQuarters,
  output logic      [2:0]  negInputSel,
  output logic      [2:0]  posInputSel,
  output logic             negInputValid,
  output logic             refExternal,
  output logic             negRefBufEn,
  output logic             posRefBufEn,
  output logic             lowLatency,
  output logic      [4:0]  clockDivide,
  output logic      [14:0] osr,
  output logic             modPowerOn,
  output logic             adcOn,
  output logic             filterReset,
  output logic             conversionIrq
);

  // ******************************************************
  // Declarations
  // ******************************************************
  logic [7:0]  gain_reg,  gain_next;
  logic [7:0]  incfg_reg, incfg_next;
  logic [7:0]  chsel_reg, chsel_next;
  logic [7:0]  ctrl0_reg, ctrl0_next;
  logic [7:0]  ctrl1_reg, ctrl1_next;
  logic [23:0] res_reg,   res_next;
  logic [7:0]  rdData_reg, rdData_next;
  logic        irq_reg,   irq_next;
  adc_ctl_pkg::conv_state_e state_reg, state_next;
  logic [4:0]  psc_reg,   psc_next;
  logic [15:0] word_reg,  word_next;
  logic [2:0]  refDiv_reg, refDiv_next;
  logic [3:0]  convG_reg, convG_next;
  logic [7:0]  ampG_reg,  ampG_next;
  logic        offNeg_reg, offNeg_next;
  logic [1:0]  offQ_reg,  offQ_next;
  logic        negOk_reg, negOk_next;
  logic [4:0]  div_reg,   div_next;
  logic [14:0] osr_reg,   osr_next;
  logic [15:0] wordLen;
  logic        pscLast;
  logic        done;
  logic        store;

  // Power of two of a small code, used by every gain decode
  function automatic logic [7:0] pow2(input logic [2:0] code);
    pow2 = 8'h01 << code;
  endfunction : pow2

  // ******************************************************
  // Register file
  // ******************************************************

  // Writes land masked, so unused bits stay zero, except control 1 bit 5
  always_comb begin : regNextProc
    gain_next  = gain_reg;
    incfg_next = incfg_reg;
    chsel_next = chsel_reg;
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    if (wrStb) begin
      unique case (addr)
        adc_ctl_pkg::OFS_GAIN:
          gain_next = wrData & adc_ctl_pkg::GAIN_MASK;
        adc_ctl_pkg::OFS_INCFG:
          incfg_next = wrData & adc_ctl_pkg::INCFG_MASK;
        adc_ctl_pkg::OFS_CHSEL:
          chsel_next = wrData & adc_ctl_pkg::CHSEL_MASK;
        adc_ctl_pkg::OFS_CTRL0:
          ctrl0_next = wrData & adc_ctl_pkg::CTRL0_MASK;
        adc_ctl_pkg::OFS_CTRL1:
          ctrl1_next = wrData & adc_ctl_pkg::CTRL1_MASK;
        default: begin
        end
      endcase
    end
    // A finished word beats a same-cycle software clear
    if (store) begin
      ctrl1_next[adc_ctl_pkg::C1_EOC] = 1'b1;
    end
  end

  // Result capture: all 24 bits move in one edge, never byte by byte
  always_comb begin : resNextProc
    res_next = res_reg;
    irq_next = 1'b0;
    if (store) begin
      res_next = resultIn;
      irq_next = 1'b1;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin : readNextProc
    rdData_next = 8'h00;
    if (rdStb) begin
      unique case (addr)
        adc_ctl_pkg::OFS_GAIN:  rdData_next = gain_reg;
        adc_ctl_pkg::OFS_INCFG: rdData_next = incfg_reg;
        adc_ctl_pkg::OFS_CHSEL: rdData_next = chsel_reg;
        adc_ctl_pkg::OFS_RESH:  rdData_next = res_reg[23:16];
        adc_ctl_pkg::OFS_RESM:  rdData_next = res_reg[15:8];
        adc_ctl_pkg::OFS_RESL:  rdData_next = res_reg[7:0];
        adc_ctl_pkg::OFS_CTRL0: rdData_next = ctrl0_reg;
        adc_ctl_pkg::OFS_CTRL1: rdData_next = ctrl1_reg;
        default:                rdData_next = 8'h00;
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge clock) begin : regFileProc
    if (rst) begin
      gain_reg   <= adc_ctl_pkg::ZERO_RST;
      incfg_reg  <= adc_ctl_pkg::INCFG_RST;
      chsel_reg  <= adc_ctl_pkg::ZERO_RST;
      ctrl0_reg  <= adc_ctl_pkg::CTRL0_RST;
      ctrl1_reg  <= adc_ctl_pkg::ZERO_RST;
      res_reg    <= 24'h000000;
      rdData_reg <= 8'h00;
      irq_reg    <= 1'b0;
    end else begin
      gain_reg   <= gain_next;
      incfg_reg  <= incfg_next;
      chsel_reg  <= chsel_next;
      ctrl0_reg  <= ctrl0_next;
      ctrl1_reg  <= ctrl1_next;
      res_reg    <= res_next;
      rdData_reg <= rdData_next;
      irq_reg    <= irq_next;
    end
  end

  // ******************************************************
  // Operating state and word timer
  // ******************************************************

  // Word length in converter clocks: chop factor times ratio
  assign wordLen = lowLatency ? {1'b0, osr_reg}
                              : {osr_reg, 1'b0};
  assign pscLast = (psc_reg == div_reg - 5'd1);
  assign done    = (state_reg == adc_ctl_pkg::ST_RUN) && pscLast &&
                   (word_reg == wordLen - 16'd1);
  // While latched the word is thrown away: no flag, no request
  assign store   = done && !ctrl1_reg[adc_ctl_pkg::C1_LAT];

  // Power-off outranks sleep, sleep outranks soft reset
  always_comb begin : stateNextProc
    state_next = adc_ctl_pkg::ST_RUN;
    psc_next   = 5'd0;
    word_next  = 16'd0;
    if (ctrl0_reg[adc_ctl_pkg::C0_OFF]) begin
      state_next = adc_ctl_pkg::ST_OFF;
    end else if (ctrl0_reg[adc_ctl_pkg::C0_SLP]) begin
      state_next = adc_ctl_pkg::ST_SLEEP;
    end else if (ctrl0_reg[adc_ctl_pkg::C0_SRST]) begin
      state_next = adc_ctl_pkg::ST_RESET;
    end
    // Counters sit at zero outside run, so leaving reset starts a word
    if (state_reg == adc_ctl_pkg::ST_RUN &&
        state_next == adc_ctl_pkg::ST_RUN) begin
      psc_next  = pscLast ? 5'd0 : psc_reg + 5'd1;
      word_next = word_reg;
      if (pscLast) begin
        word_next = done ? 16'd0 : word_reg + 16'd1;
      end
    end
  end

  // State and counter storage
  always_ff @(posedge clock) begin : stateProc
    if (rst) begin
      state_reg <= adc_ctl_pkg::ST_OFF;
      psc_reg   <= 5'd0;
      word_reg  <= 16'd0;
    end else begin
      state_reg <= state_next;
      psc_reg   <= psc_next;
      word_reg  <= word_next;
    end
  end

  // ******************************************************
  // Analog control decode
  // ******************************************************

  // Decoded settings are registered so the analog side sees no glitches
  always_comb begin : anaNextProc
    logic [1:0] refCode;
    logic [2:0] trim;
    logic [2:0] negCode;
    refCode = gain_reg[adc_ctl_pkg::G_REF +: 2];
    trim    = incfg_reg[adc_ctl_pkg::I_TRIM +: 3];
    negCode = chsel_reg[adc_ctl_pkg::S_NEG +: 3];
    // Reserved reference code drives a zero divisor, easy to spot
    refDiv_next = (refCode == adc_ctl_pkg::REF_RSVD) ? 3'd0
                : 3'(pow2({1'b0, refCode}));
    convG_next  = 4'(pow2({1'b0,
                  gain_reg[adc_ctl_pkg::G_CONV +: 2]}));
    ampG_next   = pow2(gain_reg[adc_ctl_pkg::G_AMP +: 3]);
    offQ_next   = trim[1:0];
    offNeg_next = trim[2] && (trim[1:0] != 2'b00);
    negOk_next  = !(negCode >= adc_ctl_pkg::NEG_LO_R &&
                    negCode <= adc_ctl_pkg::NEG_HI_R);
    div_next    = ctrl1_reg[adc_ctl_pkg::C1_FAST]
                ? adc_ctl_pkg::DIV_FAST : adc_ctl_pkg::DIV_SLOW;
    osr_next    = adc_ctl_pkg::OSR_MAX >>
                  ctrl0_reg[adc_ctl_pkg::C0_RATE +: 3];
  end

  // Decode storage; reset values match the register reset values
  always_ff @(posedge clock) begin : anaProc
    if (rst) begin
      refDiv_reg <= 3'd1;
      convG_reg  <= 4'd1;
      ampG_reg   <= 8'h01;
      offNeg_reg <= 1'b0;
      offQ_reg   <= 2'd0;
      negOk_reg  <= 1'b1;
      div_reg    <= adc_ctl_pkg::DIV_SLOW;
      osr_reg    <= adc_ctl_pkg::OSR_MAX;
    end else begin
      refDiv_reg <= refDiv_next;
      convG_reg  <= convG_next;
      ampG_reg   <= ampG_next;
      offNeg_reg <= offNeg_next;
      offQ_reg   <= offQ_next;
      negOk_reg  <= negOk_next;
      div_reg    <= div_next;
      osr_reg    <= osr_next;
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************

  // Register bits go straight out; decoded values come from their flops
  assign rdData          = rdData_reg;
  assign refGainDiv      = refDiv_reg;
  assign convGain        = convG_reg;
  assign ampGain         = ampG_reg;
  assign commonLevelHigh = incfg_reg[adc_ctl_pkg::I_CM];
  assign inputShort      = incfg_reg[adc_ctl_pkg::I_SHRT];
  assign offsetNeg       = offNeg_reg;
  assign offsetQuarters  = offQ_reg;
  assign negInputSel     = chsel_reg[adc_ctl_pkg::S_NEG +: 3];
  assign posInputSel     = chsel_reg[adc_ctl_pkg::S_POS +: 3];
  assign negInputValid   = negOk_reg;
  assign refExternal     = ctrl0_reg[adc_ctl_pkg::C0_REF];
  assign negRefBufEn     = ctrl1_reg[adc_ctl_pkg::C1_NBUF];
  assign posRefBufEn     = ctrl1_reg[adc_ctl_pkg::C1_PBUF];
  assign lowLatency      = ctrl1_reg[adc_ctl_pkg::C1_LL];
  assign clockDivide     = div_reg;
  assign osr             = osr_reg;
  assign modPowerOn      = (state_reg != adc_ctl_pkg::ST_OFF);
  assign adcOn           = (state_reg == adc_ctl_pkg::ST_RUN) ||
                           (state_reg == adc_ctl_pkg::ST_RESET);
  assign filterReset     = (state_reg == adc_ctl_pkg::ST_RESET);
  assign conversionIrq   = irq_reg;

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_RSVD_ZERO: assert property (
    $past(rdStb) && $past(addr) == adc_ctl_pkg::OFS_CTRL1
    |-> rdData[0] == 1'b0)
    else $error("Unused control bit read as one");

  AST_OFF_WINS: assert property (
    ctrl0_reg[adc_ctl_pkg::C0_OFF] |=> !modPowerOn && !filterReset)
    else $error("Converter powered while off bit set");

  AST_LATCH_HOLD: assert property (
    ctrl1_reg[adc_ctl_pkg::C1_LAT] |=> $stable(res_reg) && !irq_reg)
    else $error("Result changed while latched");

  AST_CAPTURE: assert property (
    done && !ctrl1_reg[adc_ctl_pkg::C1_LAT]
    |=> res_reg == $past(resultIn) && irq_reg
        && ctrl1_reg[adc_ctl_pkg::C1_EOC])
    else $error("Finished word not captured");

  AST_EOC_STICKY: assert property (
    ctrl1_reg[adc_ctl_pkg::C1_EOC] && !wrStb && !done
    |=> ctrl1_reg[adc_ctl_pkg::C1_EOC])
    else $error("End flag dropped without a write");

  AST_RESTART: assert property (
    filterReset ##1 state_reg == adc_ctl_pkg::ST_RUN
    |-> word_reg == 16'd0 && psc_reg == 5'd0 ##1 psc_reg == 5'd1)
    else $error("Word did not restart after soft reset");

  AST_AMP_GAIN: assert property (
    ##1 ampGain == (8'h01 << $past(gain_reg[adc_ctl_pkg::G_AMP +: 3])))
    else $error("Amplifier gain decode wrong");

  AST_OSR: assert property (
    ##1 osr == (adc_ctl_pkg::OSR_MAX >>
                $past(ctrl0_reg[adc_ctl_pkg::C0_RATE +: 3])))
    else $error("Oversampling ratio decode wrong");

  AST_SHORT: assert property (
    wrStb && addr == adc_ctl_pkg::OFS_INCFG
    |=> inputShort == $past(wrData[adc_ctl_pkg::I_SHRT]))
    else $error("Input short does not follow its bit");

  AST_SLEEP: assert property (
    !ctrl0_reg[adc_ctl_pkg::C0_OFF] && ctrl0_reg[adc_ctl_pkg::C0_SLP]
    |=> modPowerOn && !adcOn)
    else $error("Sleep did not stop the converter");

  AST_REF_RSVD: assert property (
    gain_reg[adc_ctl_pkg::G_REF +: 2] == adc_ctl_pkg::REF_RSVD
    |=> refGainDiv == 3'd0)
    else $error("Reserved reference code not flagged");

  AST_OFFSET_ZERO: assert property (
    offsetQuarters == 2'b00 |-> !offsetNeg)
    else $error("Zero offset marked negative");

  AST_IRQ_PULSE: assert property (
    conversionIrq |=> !conversionIrq)
    else $error("Conversion request longer than one cycle");

  COV_STORE: cover property (store);
  COV_DISCARD: cover property (done && ctrl1_reg[adc_ctl_pkg::C1_LAT]);
  COV_SRST: cover property (filterReset ##1 !filterReset && adcOn);
  COV_SLEEP: cover property (state_reg == adc_ctl_pkg::ST_SLEEP);

endmodule : sigma_delta_adc_control_regs
`default_nettype wire

// ===== include/adc_ctl_pkg.sv
// Constants and types shared by the converter control register block
`default_nettype none
package adc_ctl_pkg;
  // ******************************************************
  // Register map (offsets on the plain register port)
  // ******************************************************
  localparam int         ADDR_W    = 4;
  localparam logic [3:0] OFS_GAIN  = 4'h0;
  localparam logic [3:0] OFS_INCFG = 4'h1;
  localparam logic [3:0] OFS_CHSEL = 4'h2;
  localparam logic [3:0] OFS_RESH  = 4'h3;
  localparam logic [3:0] OFS_RESM  = 4'h4;
  localparam logic [3:0] OFS_RESL  = 4'h5;
  localparam logic [3:0] OFS_CTRL0 = 4'h6;
  localparam logic [3:0] OFS_CTRL1 = 4'h7;

  // ******************************************************
  // Implemented-bit masks and reset values
  // ******************************************************
  localparam logic [7:0] GAIN_MASK  = 8'h7f;
  localparam logic [7:0] INCFG_MASK = 8'hce;
  localparam logic [7:0] CHSEL_MASK = 8'h3f;
  localparam logic [7:0] CTRL0_MASK = 8'hfd;
  localparam logic [7:0] CTRL1_MASK = 8'hfe;
  localparam logic [7:0] ZERO_RST   = 8'h00;
  localparam logic [7:0] INCFG_RST  = 8'h80;
  localparam logic [7:0] CTRL0_RST  = 8'h20;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int G_REF  = 5;
  localparam int G_CONV = 3;
  localparam int G_AMP  = 0;
  localparam int I_CM   = 7;
  localparam int I_SHRT = 6;
  localparam int I_TRIM = 1;
  localparam int I_SIGN = 3;
  localparam int S_NEG  = 3;
  localparam int S_POS  = 0;
  localparam int C0_SRST = 7;
  localparam int C0_SLP  = 6;
  localparam int C0_OFF  = 5;
  localparam int C0_RATE = 2;
  localparam int C0_REF  = 0;
  localparam int C1_LL   = 7;
  localparam int C1_FAST = 6;
  localparam int C1_NBUF = 4;
  localparam int C1_PBUF = 3;
  localparam int C1_LAT  = 2;
  localparam int C1_EOC  = 1;

  // ******************************************************
  // Timing and decode constants
  // ******************************************************
  localparam int          RES_W    = 24;
  localparam logic [4:0]  DIV_SLOW = 5'd30;
  localparam logic [4:0]  DIV_FAST = 5'd12;
  localparam logic [14:0] OSR_MAX  = 15'h4000;
  localparam logic [1:0]  REF_RSVD = 2'b11;
  localparam logic [2:0]  NEG_LO_R = 3'b010;
  localparam logic [2:0]  NEG_HI_R = 3'b100;

  // Converter operating state, Gray along off, reset, run
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_RESET = 2'b01,
    ST_RUN   = 2'b11,
    ST_SLEEP = 2'b10
  } conv_state_e;
endpackage : adc_ctl_pkg
`default_nettype wire

// ===== bench/adc_front_model.sv
// Behavioural modulator and decimation filter feeding the result word
`default_nettype none
module adc_front_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        adcOn,
  input  wire logic        filterReset,
  input  wire logic [23:0] word,
  output var  logic [23:0] resultIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Word is only valid while converting; otherwise it flickers every
  // cycle so a stray sample can never match the expected word by luck
  always @(posedge clock) begin
    if (rst) begin
      resultIn <= 24'h5a5a5a;
    end else if (!adcOn || filterReset) begin
      resultIn <= ~resultIn;
    end else begin
      resultIn <= word;
    end
  end
endmodule : adc_front_model
`default_nettype wire

// ===== bench/test_sigma_delta_adc_control_regs.sv
// Self-checking bench for the converter control register block
`default_nettype none
module test_sigma_delta_adc_control_regs;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals and register offsets
  // ****************************************
  localparam logic [3:0] GAIN  = adc_ctl_pkg::OFS_GAIN;
  localparam logic [3:0] INCFG = adc_ctl_pkg::OFS_INCFG;
  localparam logic [3:0] CHSEL = adc_ctl_pkg::OFS_CHSEL;
  localparam logic [3:0] CTRL0 = adc_ctl_pkg::OFS_CTRL0;
  localparam logic [3:0] CTRL1 = adc_ctl_pkg::OFS_CTRL1;
  typedef struct {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_s;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wrData = 8'h00;
  logic        wrStb = 1'b0;
  logic        rdStb = 1'b0;
  logic [23:0] modelWord = 24'ha1b2c3;
  logic [7:0]  rdData, ampGain;
  logic [23:0] resultIn;
  logic [2:0]  refGainDiv, negInputSel, posInputSel;
  logic [3:0]  convGain;
  logic [1:0]  offsetQuarters;
  logic [4:0]  clockDivide;
  logic [14:0] osr;
  logic        commonLevelHigh, inputShort, offsetNeg, negInputValid;
  logic        refExternal, negRefBufEn, posRefBufEn, lowLatency;
  logic        modPowerOn, adcOn, filterReset, conversionIrq;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          i;
  int          n;
  logic [7:0]  resetVals [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00,
                                 8'h00, 8'h20, 8'h00};
  // Masked writes, read-only result and an unmapped place
  row_s rows [9] = '{'{GAIN, 8'hff, 8'h7f}, '{INCFG, 8'hff, 8'hce},
    '{CHSEL, 8'hff, 8'h3f}, '{CTRL0, 8'hff, 8'hfd},
    '{CTRL1, 8'hff, 8'hfe}, '{CTRL1, 8'h00, 8'h00},
    '{4'h3, 8'h55, 8'h00}, '{4'h9, 8'hff, 8'h00}, '{GAIN, 8'h2a, 8'h2a}};

  // Clock of 100 ns period
  always #50 clock = ~clock;

  sigma_delta_adc_control_regs sigma_delta_adc_control_regs_inst (
    .clock(clock), .rst(rst), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .resultIn(resultIn),
    .refGainDiv(refGainDiv), .convGain(convGain), .ampGain(ampGain),
    .commonLevelHigh(commonLevelHigh), .inputShort(inputShort),
    .offsetNeg(offsetNeg), .offsetQuarters(offsetQuarters),
    .negInputSel(negInputSel), .posInputSel(posInputSel),
    .negInputValid(negInputValid), .refExternal(refExternal),
    .negRefBufEn(negRefBufEn), .posRefBufEn(posRefBufEn),
    .lowLatency(lowLatency), .clockDivide(clockDivide), .osr(osr),
    .modPowerOn(modPowerOn), .adcOn(adcOn), .filterReset(filterReset),
    .conversionIrq(conversionIrq));

  adc_front_model adc_front_model_inst (
    .clock(clock), .rst(rst), .adcOn(adcOn), .filterReset(filterReset),
    .word(modelWord), .resultIn(resultIn));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [23:0] expv,
                       input logic [23:0] seen);
    comparisons++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clock);
    wrStb  <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input string what);
    @(posedge clock);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1;
    check(what, 24'(e), 24'(rdData));
  endtask : rd

  // Decoded outputs trail the register by one cycle
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  task automatic give_verdict;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Bounded wait for the end-of-word pulse; a miss ends the run
  task automatic wait_irq(input int limit, output int cnt);
    cnt = 0;
    while (conversionIrq !== 1'b1) begin
      @(posedge clock);
      #1;
      cnt++;
      if (cnt > limit) begin
        n_mismatch++;
        $display("mismatch conversionIrq expected 1 seen 0");
        give_verdict();
      end
    end
  endtask : wait_irq

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      rd(i[3:0], resetVals[i], "reset value");
    end
    @(posedge clock);
    #1;
    check("rdData idle", 24'h0, 24'(rdData));
    check("modPowerOn", 24'h0, 24'(modPowerOn));
    for (i = 0; i < 9; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "row read");
    end
    for (i = 0; i < 8; i++) begin
      wr(GAIN, 8'((i % 4) * 40 + i));
      settle();
      check("refGainDiv", 24'((i % 4 == 3) ? 0 : 1 << (i % 4)),
            24'(refGainDiv));
      check("convGain", 24'(1 << (i % 4)), 24'(convGain));
      check("ampGain", 24'(1 << i), 24'(ampGain));
      wr(INCFG, 8'(i * 2));
      settle();
      check("offsetNeg", 24'(i > 4), 24'(offsetNeg));
      check("offsetQuarters", 24'(i % 4), 24'(offsetQuarters));
      check("inputShort", 24'h0, 24'(inputShort));
      wr(CHSEL, 8'(i * 9));
      settle();
      check("negInputSel", 24'(i), 24'(negInputSel));
      check("posInputSel", 24'(i), 24'(posInputSel));
      check("negInputValid", 24'(i < 2 || i > 4),
            24'(negInputValid));
      wr(CTRL0, 8'(8'he0 + i * 4 + i % 2));
      settle();
      check("osr", 24'(16384 >> i), 24'(osr));
      check("refExternal", 24'(i % 2), 24'(refExternal));
      check("modPowerOn", 24'h0, 24'(modPowerOn));
    end
    wr(INCFG, 8'hc0);
    settle();
    check("commonLevelHigh", 24'h1, 24'(commonLevelHigh));
    check("inputShort", 24'h1, 24'(inputShort));
    for (i = 0; i < 4; i++) begin
      wr(CTRL1, 8'(i * 64 + 24 * (i % 2)));
      settle();
      check("lowLatency", 24'(i / 2), 24'(lowLatency));
      check("clockDivide", 24'((i % 2) ? 12 : 30), 24'(clockDivide));
      check("negRefBufEn", 24'(i % 2), 24'(negRefBufEn));
      check("posRefBufEn", 24'(i % 2), 24'(posRefBufEn));
    end
    // Single-ended channel 0 paired with the common level
    wr(CHSEL, 8'h30);
    wr(CTRL1, 8'h40);
    wr(CTRL0, 8'h1c);
    wait_irq(4000, n);
    check("normal word", 24'h1, 24'(n >= 3072 && n <= 3080));
    @(posedge clock);
    #1;
    check("irq pulse", 24'h0, 24'(conversionIrq));
    check("run adcOn", 24'h1, 24'(adcOn));
    check("run filterReset", 24'h0, 24'(filterReset));
    rd(4'h3, 8'ha1, "result high");
    rd(4'h4, 8'hb2, "result middle");
    rd(4'h5, 8'hc3, "result low");
    rd(CTRL1, 8'h42, "flag set");
    wr(CTRL1, 8'h40);
    rd(CTRL1, 8'h40, "flag cleared");
    // Latch holds the old word while conversions go on
    wr(CTRL1, 8'h44);
    modelWord <= 24'h0f1e2d;
    n = 0;
    repeat (3300) begin
      @(posedge clock);
      #1;
      if (conversionIrq === 1'b1) n++;
    end
    check("irq while latched", 24'h0, 24'(n));
    rd(4'h5, 8'hc3, "latched low");
    rd(CTRL1, 8'h44, "flag while latched");
    wr(CTRL1, 8'h40);
    wait_irq(3400, n);
    rd(4'h5, 8'h2d, "new low");
    // Soft reset pulse then a low-latency word
    wr(CTRL1, 8'hc2);
    wr(CTRL0, 8'h9c);
    settle();
    check("filterReset", 24'h1, 24'(filterReset));
    wr(CTRL0, 8'h1c);
    wait_irq(2000, n);
    check("low latency word", 24'h1, 24'(n >= 1536 && n <= 1544));
    wr(CTRL0, 8'h5c);
    settle();
    check("sleep power", 24'h1, 24'(modPowerOn));
    check("sleep adcOn", 24'h0, 24'(adcOn));
    wr(CTRL0, 8'h20);
    settle();
    check("power off", 24'h0, 24'(modPowerOn));
    give_verdict();
  end
endmodule : test_sigma_delta_adc_control_regs
`default_nettype wire
